// >>> hdl/hrd_consts.vh
// constants for the run-time reconfiguration and slot diagnostics block
`ifndef HRD_CONSTS_VH
`define HRD_CONSTS_VH

// register byte offsets (word aligned)
`define HRD_ADDR_W         8
`define HRD_REG_CTRL       8'h00
`define HRD_REG_PARAM      8'h04
`define HRD_REG_STATUS     8'h08
`define HRD_REG_IRQ_STAT   8'h0C
`define HRD_REG_IRQ_MASK   8'h10
`define HRD_REG_SVC_ADDR   8'h14
`define HRD_REG_CFG_ACT    8'h18
`define HRD_REG_CFG_PEND   8'h1C
`define HRD_REG_SETTINGS   8'h20
`define HRD_REG_DIAG_BASE  8'h40
`define HRD_REG_SLOT_BASE  8'h80

// reconfig parameter byte fields
`define HRD_DELAY_LSB      0
`define HRD_DELAY_MSB      5
`define HRD_DELAY_EN_BIT   7
`define HRD_PARAM_RST      8'h00

// ctrl register fields
`define HRD_CTRL_RED_LSB   0
`define HRD_CTRL_RED_MSB   1
`define HRD_CTRL_DUAL_BIT  2
`define HRD_CTRL_RST       32'h0000_0000

// redundancy modes
`define HRD_RED_NONE       2'h0
`define HRD_RED_APPL       2'h1
`define HRD_RED_LINE       2'h2

// slot status codes
`define HRD_SLOT_INVALID   2'h0
`define HRD_SLOT_FAULT     2'h1
`define HRD_SLOT_WRONG     2'h2
`define HRD_SLOT_MISSING   2'h3

// diagnostics geometry
`define HRD_SLOTS          48
`define HRD_DIAG_BYTES     12
`define HRD_DIAG_FIRST_BIT 48
`define HRD_DIAG_LAST_BIT  143

// service bus offset for the redundant unit
`define HRD_SVC_RED_OFS    8'h80

// default settings word: scaling 0, 50 Hz, individual status, outputs w/o status,
// hart on with scanning, no supply monitor, no redundancy, watchdog off, clear supp off
`define HRD_SETTINGS_RST   32'h0000_0050

// timing
`define HRD_CLK_HZ         10000000
`define HRD_TICK_MS        1
`define HRD_STEP_MS        100
`define HRD_MAX_DELAY_MS   6300

// interrupt bits
`define HRD_IRQ_APPLIED    0
`define HRD_IRQ_FREEZE_END 1
`define HRD_IRQ_RED_COPY   2
`define HRD_IRQ_CFG_KEPT   3
`define HRD_IRQ_W          4

`endif

// >>> hdl/hrd_ms_tick.v
// millisecond time base derived from the core clock
`include "hrd_consts.vh"

module hrd_ms_tick #(
   parameter CYCLES_PER_MS = (`HRD_CLK_HZ / 1000) * `HRD_TICK_MS
)(
   input  wire core_clk_i,
   input  wire rst_i,
   output reg  tick_o
);

   reg [15:0] cnt_r;

   always @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cnt_r  <= 16'h0000;
         tick_o <= 1'b0;
      end
      else if (cnt_r == CYCLES_PER_MS[15:0] - 16'h0001)
      begin
         cnt_r  <= 16'h0000;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 16'h0001;
         tick_o <= 1'b0;
      end
   end

endmodule // hrd_ms_tick

// >>> hdl/hrd_slot_mem.v
// slot status store, 48 words of 2 bits, registered read
`include "hrd_consts.vh"

module hrd_slot_mem (
   input  wire       core_clk_i,
   input  wire       we_i,
   input  wire [5:0] waddr_i,
   input  wire [1:0] wdata_i,
   input  wire [5:0] raddr_i,
   output reg  [1:0] rdata_o
);

   reg [1:0] mem_r [0:`HRD_SLOTS-1];

   always @(posedge core_clk_i)
   begin
      if (we_i)
         mem_r[waddr_i] <= wdata_i;
      rdata_o <= mem_r[raddr_i];
   end

endmodule // hrd_slot_mem

// >>> hdl/hrd_top.v
// run-time reconfiguration, redundancy settings and slot diagnostics
// Notes on behaviour
// - delay setting is bits 0..5, times 100 ms, up to 6300 ms; bit 6 unused
// - bit 7 of the parameter byte enables the freeze delay
// - outputs stay frozen at old values while the delay runs
// - without the dual scheme, new settings take effect as soon as transferred
// - dual scheme: matching master config activates pending one, drops old
// - dual scheme: mismatched restart keeps old configuration active
// - application redundancy: no settings passed, own bus addresses
// - line redundancy: settings copied once partner connected and powered
// - line redundancy: both units share one fieldbus address
// - redundant service address is primary base address plus 128
// - extended diagnostics add 12 bytes, 2 bits for each of 48 slots
// - slot field spans bit 48 (slot 1) to bit 143 (slot 48)
// - codes: 00 invalid, 01 fault, 10 wrong module, 11 missing
// - default settings as documented preferred values
`include "hrd_consts.vh"

module hrd_top (
   input  wire        core_clk_i,
   input  wire        rst_i,
   // avalon-mm slave
   input  wire [7:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   output wire        irq_o,
   // configuration transfer from the fieldbus side
   input  wire        cfg_load_i,
   input  wire [31:0] cfg_data_i,
   input  wire        bus_start_i,
   input  wire [31:0] bus_cfg_i,
   // process outputs
   input  wire [31:0] out_data_i,
   output reg  [31:0] out_data_o,
   output wire        outputs_frozen_o,
   // redundancy partner
   input  wire        partner_present_i,
   input  wire        partner_powered_i,
   input  wire [6:0]  own_bus_addr_i,
   input  wire [7:0]  svc_base_addr_i,
   input  wire        is_redundant_i,
   output reg         settings_copy_o,
   output reg  [31:0] settings_tx_o,
   output wire [6:0]  bus_addr_o,
   output wire [7:0]  svc_addr_o,
   // slot status updates
   input  wire        slot_we_i,
   input  wire [5:0]  slot_idx_i,
   input  wire [1:0]  slot_code_i,
   // extended diagnostic byte read port
   input  wire [3:0]  diag_byte_idx_i,
   output reg  [7:0]  diag_byte_o
);

   localparam [31:0] STEP_LAST = `HRD_STEP_MS - 1;

   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_FREEZE = 2'h1;

   function [1:0] slot_of_byte;
      input [7:0] b;
      input [1:0] k;
      begin
         slot_of_byte = b[{k, 1'b0} +: 2];
      end
   endfunction

   reg  [31:0] ctrl_r;
   reg  [7:0]  param_r;
   reg  [31:0] settings_r;
   reg  [31:0] cfg_act_r;
   reg  [31:0] cfg_pend_r;
   reg         pend_valid_r;
   reg  [`HRD_IRQ_W-1:0] irq_stat_r;
   reg  [`HRD_IRQ_W-1:0] irq_mask_r;
   reg  [1:0]  state_r;
   reg  [5:0]  steps_r;
   reg  [6:0]  ms_cnt_r;
   reg  [1:0]  slot_sh_r [0:`HRD_SLOTS-1];
   reg         partner_up_r;
   reg  [1:0]  rd_stage_r;
   wire        tick;
   wire [1:0]  mem_rdata;
   wire [`HRD_IRQ_W-1:0] irq_ev;
   wire [1:0]  red_mode = ctrl_r[`HRD_CTRL_RED_MSB:`HRD_CTRL_RED_LSB];
   wire        dual     = ctrl_r[`HRD_CTRL_DUAL_BIT];
   wire        wr       = avs_write_i;
   wire        freeze_start;
   wire        freeze_done;
   wire        partner_up = partner_present_i & partner_powered_i;
   wire        rd_pend_r  = rd_stage_r[0];
   wire        slot_rd    = (avs_address_i >= `HRD_REG_SLOT_BASE);
   integer     i;
   integer     j;

   hrd_ms_tick u_tick (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .tick_o     (tick)
   );

   hrd_slot_mem u_mem (
      .core_clk_i (core_clk_i),
      .we_i       (slot_we_i),
      .waddr_i    (slot_idx_i),
      .wdata_i    (slot_code_i),
      .raddr_i    (avs_address_i[7:2] - 6'h20),
      .rdata_o    (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // configuration apply and freeze delay

   wire apply_direct = cfg_load_i & ~dual;
   wire dual_match   = bus_start_i & dual & pend_valid_r & (bus_cfg_i == cfg_pend_r);
   wire dual_keep    = bus_start_i & dual & pend_valid_r & (bus_cfg_i != cfg_pend_r);
   wire applied      = apply_direct | dual_match;

   assign freeze_start = applied & param_r[`HRD_DELAY_EN_BIT]
                         & (param_r[`HRD_DELAY_MSB:`HRD_DELAY_LSB] != 6'h00);
   assign freeze_done  = (state_r == ST_FREEZE) & (steps_r == 6'h00);

   always @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state_r      <= ST_IDLE;
         steps_r      <= 6'h00;
         ms_cnt_r     <= 7'h00;
         cfg_act_r    <= 32'h0000_0000;
         cfg_pend_r   <= 32'h0000_0000;
         pend_valid_r <= 1'b0;
      end
      else
      begin
         if (apply_direct)
            cfg_act_r <= cfg_data_i;
         else if (cfg_load_i)
         begin
            cfg_pend_r   <= cfg_data_i;
            pend_valid_r <= 1'b1;
         end
         else if (dual_match)
         begin
            cfg_act_r    <= cfg_pend_r;
            pend_valid_r <= 1'b0;
         end
         case (state_r)
            ST_IDLE:
            begin
               if (freeze_start)
               begin
                  state_r  <= ST_FREEZE;
                  steps_r  <= param_r[`HRD_DELAY_MSB:`HRD_DELAY_LSB];
                  ms_cnt_r <= 7'h00;
               end
            end
            ST_FREEZE:
            begin
               if (freeze_start)
               begin
                  steps_r  <= param_r[`HRD_DELAY_MSB:`HRD_DELAY_LSB];
                  ms_cnt_r <= 7'h00;
               end
               else if (steps_r == 6'h00)
                  state_r <= ST_IDLE;
               else if (tick)
               begin
                  if ({25'h0, ms_cnt_r} == STEP_LAST)
                  begin
                     ms_cnt_r <= 7'h00;
                     steps_r  <= steps_r - 6'h01;
                  end
                  else
                     ms_cnt_r <= ms_cnt_r + 7'h01;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   assign outputs_frozen_o = (state_r == ST_FREEZE);

   // hold outputs at old values while the delay runs
   always @(posedge core_clk_i)
   begin
      if (rst_i)
         out_data_o <= 32'h0000_0000;
      else if (!outputs_frozen_o && !freeze_start)
         out_data_o <= out_data_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // redundancy

   assign bus_addr_o = own_bus_addr_i;
   assign svc_addr_o = is_redundant_i ? (svc_base_addr_i + `HRD_SVC_RED_OFS)
                                      : svc_base_addr_i;

   always @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         partner_up_r    <= 1'b0;
         settings_copy_o <= 1'b0;
         settings_tx_o   <= 32'h0000_0000;
      end
      else
      begin
         partner_up_r    <= partner_up;
         // copy on connect and on every settings change while line redundant
         settings_copy_o <= (red_mode == `HRD_RED_LINE) & partner_up & ~is_redundant_i
                            & ((~partner_up_r) | applied | (wr && avs_address_i ==
                               `HRD_REG_SETTINGS));
         settings_tx_o   <= (red_mode == `HRD_RED_LINE) ? settings_r : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // extended diagnostics

   always @(posedge core_clk_i)
   begin
      if (slot_we_i)
         slot_sh_r[slot_idx_i] <= slot_code_i;
   end

   always @(posedge core_clk_i)
   begin
      if (rst_i)
         diag_byte_o <= 8'h00;
      else
         // byte k carries slots 4k+1..4k+4, i.e. field bits 48+8k..55+8k
         for (i = 0; i < 4; i = i + 1)
            diag_byte_o[2*i +: 2] <= slot_sh_r[{diag_byte_idx_i, 2'b00} + i];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register bus and interrupts

   assign irq_ev = {dual_keep, partner_up & ~partner_up_r, freeze_done, applied};

   always @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r     <= `HRD_CTRL_RST;
         param_r    <= `HRD_PARAM_RST;
         settings_r <= `HRD_SETTINGS_RST;
         irq_mask_r <= {`HRD_IRQ_W{1'b0}};
         irq_stat_r <= {`HRD_IRQ_W{1'b0}};
      end
      else
      begin
         if (wr && avs_address_i == `HRD_REG_CTRL && avs_byteenable_i[0])
            ctrl_r[2:0] <= avs_writedata_i[2:0];
         if (wr && avs_address_i == `HRD_REG_PARAM && avs_byteenable_i[0])
            param_r <= avs_writedata_i[7:0] & 8'hBF;
         if (wr && avs_address_i == `HRD_REG_IRQ_MASK && avs_byteenable_i[0])
            irq_mask_r <= avs_writedata_i[`HRD_IRQ_W-1:0];
         if (wr && avs_address_i == `HRD_REG_SETTINGS)
         begin
            for (j = 0; j < 4; j = j + 1)
               if (avs_byteenable_i[j])
                  settings_r[8*j +: 8] <= avs_writedata_i[8*j +: 8];
         end
         // set wins over write-one-to-clear
         if (wr && avs_address_i == `HRD_REG_IRQ_STAT && avs_byteenable_i[0])
            irq_stat_r <= (irq_stat_r & ~avs_writedata_i[`HRD_IRQ_W-1:0]) | irq_ev;
         else
            irq_stat_r <= irq_stat_r | irq_ev;
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   // reads wait one cycle; slot reads wait two, as the memory output is itself registered
   assign avs_waitrequest_o = avs_read_i & ~(slot_rd ? rd_stage_r[1] : rd_stage_r[0]);

   always @(posedge core_clk_i)
   begin
      if (rst_i)
         rd_stage_r <= 2'h0;
      else
         rd_stage_r <= {rd_stage_r[0], 1'b1} & {2{avs_read_i & avs_waitrequest_o}};
   end

   always @(posedge core_clk_i)
   begin
      if (rst_i)
         avs_readdata_o <= 32'h0000_0000;
      else if (avs_read_i && !rd_pend_r)
      begin
         if (slot_rd)
            avs_readdata_o <= 32'h0000_0000;
         else if (avs_address_i >= `HRD_REG_DIAG_BASE &&
                  avs_address_i < `HRD_REG_DIAG_BASE + 8'h30)
            avs_readdata_o <= {24'h000000,
                               slot_sh_r[{avs_address_i[5:2] - 4'h0, 2'b11}],
                               slot_sh_r[{avs_address_i[5:2] - 4'h0, 2'b10}],
                               slot_sh_r[{avs_address_i[5:2] - 4'h0, 2'b01}],
                               slot_sh_r[{avs_address_i[5:2] - 4'h0, 2'b00}]};
         else
            case (avs_address_i)
               `HRD_REG_CTRL:     avs_readdata_o <= ctrl_r;
               `HRD_REG_PARAM:    avs_readdata_o <= {24'h000000, param_r};
               `HRD_REG_STATUS:   avs_readdata_o <= {28'h0000000, pend_valid_r,
                                                     partner_up_r, outputs_frozen_o,
                                                     1'b0} | {26'h0, steps_r[5:0]} << 8;
               `HRD_REG_IRQ_STAT: avs_readdata_o <= {28'h0000000, irq_stat_r};
               `HRD_REG_IRQ_MASK: avs_readdata_o <= {28'h0000000, irq_mask_r};
               `HRD_REG_SVC_ADDR: avs_readdata_o <= {24'h000000, svc_addr_o};
               `HRD_REG_CFG_ACT:  avs_readdata_o <= cfg_act_r;
               `HRD_REG_CFG_PEND: avs_readdata_o <= cfg_pend_r;
               `HRD_REG_SETTINGS: avs_readdata_o <= settings_r;
               default:           avs_readdata_o <= 32'h0000_0000;
            endcase
      end
      else if (rd_pend_r && slot_rd)
         avs_readdata_o <= {30'h0, mem_rdata};
   end

endmodule // hrd_top

// >>> tb/hrd_checker.sv
// port-level assertions for the reconfiguration and diagnostics block
module hrd_checker (
   input wire        core_clk_i,
   input wire        rst_i,
   input wire [7:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire        avs_waitrequest_o,
   input wire        cfg_load_i,
   input wire        bus_start_i,
   input wire [31:0] out_data_i,
   input wire [31:0] out_data_o,
   input wire        outputs_frozen_o,
   input wire        partner_present_i,
   input wire        partner_powered_i,
   input wire [6:0]  own_bus_addr_i,
   input wire [7:0]  svc_base_addr_i,
   input wire        is_redundant_i,
   input wire        settings_copy_o,
   input wire [6:0]  bus_addr_o,
   input wire [7:0]  svc_addr_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////
   freeze_hold_a: assert property (outputs_frozen_o && $past(outputs_frozen_o) |->
      $stable(out_data_o)) else $error("output changed while frozen");
   pass_through_a: assert property (!outputs_frozen_o && !$past(outputs_frozen_o)
      && !$past(rst_i) |-> out_data_o == $past(out_data_i)) else $error("output not passed");
   freeze_cause_a: assert property ($rose(outputs_frozen_o) |->
      $past(cfg_load_i || bus_start_i)) else $error("freeze without a new config");
   svc_addr_a: assert property (is_redundant_i |->
      svc_addr_o == svc_base_addr_i + 8'h80) else $error("service address wrong");
   bus_addr_a: assert property (bus_addr_o == own_bus_addr_i)
      else $error("bus address differs");
   copy_cause_a: assert property (settings_copy_o |->
      partner_present_i && partner_powered_i) else $error("copy without partner");
   copy_pulse_a: assert property (settings_copy_o |=> !settings_copy_o)
      else $error("copy pulse too long");
   read_wait_a: assert property ($rose(avs_read_i) && !avs_address_i[7] |->
      avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("read wait not one cycle");
   slot_wait_a: assert property ($rose(avs_read_i) && avs_address_i[7] |->
      avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("slot read wait not two cycles");
   write_nowait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
      else $error("write stalled");
endmodule // hrd_checker

bind hrd_top hrd_checker chk_u (.core_clk_i, .rst_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_waitrequest_o, .cfg_load_i, .bus_start_i, .out_data_i, .out_data_o,
   .outputs_frozen_o, .partner_present_i, .partner_powered_i, .own_bus_addr_i,
   .svc_base_addr_i, .is_redundant_i, .settings_copy_o, .bus_addr_o, .svc_addr_o);

// >>> tb/hrd_dp_master.sv
// behavioural fieldbus master: config transfers, restarts, cyclic outputs
module hrd_dp_master (
   input  wire         core_clk_i,
   output logic        cfg_load_o,
   output logic [31:0] cfg_data_o,
   output logic        bus_start_o,
   output logic [31:0] bus_cfg_o,
   output logic [31:0] out_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      cfg_load_o = 1'b0;
      cfg_data_o = 32'h0;
      bus_start_o = 1'b0;
      bus_cfg_o = 32'h0;
      out_data_o = 32'h0;
   end
   // image changes every cycle so a frozen output is told apart at once
   always @(posedge core_clk_i)
      out_data_o <= out_data_o + 32'h1;
   task automatic send_cfg(input logic [31:0] d);
      cfg_data_o <= d;
      cfg_load_o <= 1'b1;
      @(posedge core_clk_i);
      cfg_load_o <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic restart(input logic [31:0] d);
      bus_cfg_o <= d;
      bus_start_o <= 1'b1;
      @(posedge core_clk_i);
      bus_start_o <= 1'b0;
      @(posedge core_clk_i);
   endtask
endmodule // hrd_dp_master

// >>> tb/hrd_top_test.sv
// self-checking bench for hrd_top
`include "hrd_consts.vh"
module hrd_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_i = 1'b0, rst_i = 1'b1;
   logic [7:0]  avs_address_i = 8'h00, svc_base_addr_i = 8'h05;
   logic        avs_read_i = 1'b0, avs_write_i = 1'b0, is_redundant_i = 1'b1;
   logic [31:0] avs_writedata_i = 32'h0, q, hold, exp;
   logic        partner_present_i = 1'b0, partner_powered_i = 1'b0;
   logic        slot_we_i = 1'b0;
   logic [5:0]  slot_idx_i = 6'h00;
   logic [1:0]  slot_code_i = 2'h0;
   logic [3:0]  diag_byte_idx_i = 4'h0;
   logic [6:0]  own_bus_addr_i = 7'h2A;
   logic [3:0]  avs_byteenable_i = 4'hF;
   wire  [31:0] avs_readdata_o, cfg_data_i, bus_cfg_i, out_data_i, out_data_o, settings_tx_o;
   wire         avs_waitrequest_o, irq_o, cfg_load_i, bus_start_i, outputs_frozen_o;
   wire         settings_copy_o;
   wire  [6:0]  bus_addr_o;
   wire  [7:0]  svc_addr_o, diag_byte_o;
   int          fail_count = 0, cmp_count = 0, copies = 0, c0, n;

   always #50 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i)
      if (settings_copy_o === 1'b1)
         copies++;

   hrd_top dut_u (.core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .irq_o, .cfg_load_i, .cfg_data_i, .bus_start_i, .bus_cfg_i, .out_data_i,
      .out_data_o, .outputs_frozen_o, .partner_present_i, .partner_powered_i,
      .own_bus_addr_i, .svc_base_addr_i, .is_redundant_i, .settings_copy_o,
      .settings_tx_o, .bus_addr_o, .svc_addr_o, .slot_we_i, .slot_idx_i, .slot_code_i,
      .diag_byte_idx_i, .diag_byte_o);
   hrd_dp_master mst_u (.core_clk_i, .cfg_load_o(cfg_load_i), .cfg_data_o(cfg_data_i),
      .bus_start_o(bus_start_i), .bus_cfg_o(bus_cfg_i), .out_data_o(out_data_i));
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (fail_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      cmp_count++;
      if (got !== want)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= d;
      k = 0;
      do
      begin
         @(posedge core_clk_i);
         k++;
      end
      while (avs_waitrequest_o !== 1'b0 && k < 50);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      if (k >= 50)
      begin
         fail_count++;
         tally_and_finish;
      end
      @(posedge core_clk_i);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
      av(1'b0, a, 32'h0);
      chk(q, want);
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge core_clk_i);
   endtask
   function automatic logic [1:0] code(input int s);
      return 2'((s + s / 4) % 4);
   endfunction
   ////////////////////////////////////////////////////////////////
   initial
   begin
      #(100 * 90000);
      fail_count++;
      tally_and_finish;
   end
   initial
   begin
      cyc(4);
      rst_i <= 1'b0;
      rd_chk(`HRD_REG_SETTINGS, `HRD_SETTINGS_RST);
      rd_chk(`HRD_REG_CTRL, 32'h0);
      av(1'b1, `HRD_REG_PARAM, 32'hFF);
      rd_chk(`HRD_REG_PARAM, 32'hBF);
      rd_chk(8'h3C, 32'h0);
      for (n = 0; n < 48; n++)
      begin
         slot_we_i <= 1'b1;
         slot_idx_i <= 6'(n);
         slot_code_i <= code(n);
         @(posedge core_clk_i);
      end
      slot_we_i <= 1'b0;
      cyc(2);
      for (n = 0; n < 12; n++)
      begin
         diag_byte_idx_i <= 4'(n);
         cyc(2);
         exp = {24'h0, code(4*n+3), code(4*n+2), code(4*n+1), code(4*n)};
         chk({24'h0, diag_byte_o}, exp);
      end
      rd_chk(8'h84, {30'h0, code(1)});
      rd_chk(8'hFC, {30'h0, code(31)});
      rd_chk(8'h44, {24'h0, code(7), code(6), code(5), code(4)});
      av(1'b1, `HRD_REG_PARAM, 32'h05);
      av(1'b1, `HRD_REG_IRQ_MASK, 32'h1);
      mst_u.send_cfg(32'hA5A5_0001);
      chk({31'h0, outputs_frozen_o}, 32'h0);
      rd_chk(`HRD_REG_CFG_ACT, 32'hA5A5_0001);
      chk({31'h0, irq_o}, 32'h1);
      av(1'b1, `HRD_REG_IRQ_STAT, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      av(1'b1, `HRD_REG_PARAM, 32'h80);
      mst_u.send_cfg(32'hA5A5_0002);
      chk({31'h0, outputs_frozen_o}, 32'h0);
      av(1'b1, `HRD_REG_PARAM, 32'h81);
      mst_u.send_cfg(32'hA5A5_0003);
      chk({31'h0, outputs_frozen_o}, 32'h1);
      hold = out_data_o;
      cyc(10);
      chk(out_data_o, hold);
      av(1'b0, `HRD_REG_STATUS, 32'h0);
      chk(q & 32'h3F02, 32'h0102);
      rd_chk(`HRD_REG_CFG_ACT, 32'hA5A5_0003);
      // a freeze step is 1e6 cycles, so a second reset ends it
      rst_i <= 1'b1;
      cyc(4);
      rst_i <= 1'b0;
      cyc(2);
      chk({31'h0, outputs_frozen_o}, 32'h0);
      chk(out_data_o + 32'h1, out_data_i);
      avs_byteenable_i <= 4'h2;
      av(1'b1, `HRD_REG_SETTINGS, 32'hFFFF_FFFF);
      avs_byteenable_i <= 4'hF;
      rd_chk(`HRD_REG_SETTINGS, `HRD_SETTINGS_RST | 32'h0000_FF00);
      av(1'b1, `HRD_REG_CTRL, 32'h4);
      mst_u.send_cfg(32'hB1B1_0001);
      rd_chk(`HRD_REG_CFG_PEND, 32'hB1B1_0001);
      rd_chk(`HRD_REG_CFG_ACT, 32'h0);
      mst_u.restart(32'hB1B1_0001);
      rd_chk(`HRD_REG_CFG_ACT, 32'hB1B1_0001);
      mst_u.send_cfg(32'hC2C2_0002);
      mst_u.restart(32'hD3D3_0003);
      rd_chk(`HRD_REG_CFG_ACT, 32'hB1B1_0001);
      av(1'b0, `HRD_REG_IRQ_STAT, 32'h0);
      chk(q & 32'h8, 32'h8);
      chk({24'h0, svc_addr_o}, 32'h85);
      is_redundant_i <= 1'b0;
      svc_base_addr_i <= 8'h33;
      av(1'b1, `HRD_REG_CTRL, 32'h1);
      chk({24'h0, svc_addr_o}, 32'h33);
      c0 = copies;
      partner_present_i <= 1'b1;
      partner_powered_i <= 1'b1;
      cyc(10);
      chk(32'(copies - c0), 32'h0);
      chk(settings_tx_o, 32'h0);
      chk({25'h0, bus_addr_o}, 32'h2A);
      partner_present_i <= 1'b0;
      own_bus_addr_i <= 7'h11;
      av(1'b1, `HRD_REG_CTRL, 32'h2);
      partner_present_i <= 1'b1;
      for (n = 0; n < 20 && copies == c0; n++)
         @(posedge core_clk_i);
      cyc(1);
      chk(32'(copies - c0), 32'h1);
      chk(settings_tx_o, `HRD_SETTINGS_RST | 32'h0000_FF00);
      chk({25'h0, bus_addr_o}, 32'h11);
      av(1'b0, `HRD_REG_IRQ_STAT, 32'h0);
      chk(q & 32'h4, 32'h4);
      tally_and_finish;
   end
endmodule // hrd_top_test
